// File: nco_pkg.sv
package nco_pkg;

  // ---------------------------------------------------------------
  // Serial word layout
  // ---------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam int          PAYLOAD_W    = 14;
  localparam logic [3:0]  LAST_BIT     = 4'hF;
  localparam logic [1:0]  KIND_CONTROL = 2'h0;
  localparam logic [1:0]  KIND_FREQ_A  = 2'h1;
  localparam logic [1:0]  KIND_FREQ_B  = 2'h2;
  localparam logic [1:0]  KIND_PHASE   = 2'h3;
  localparam int          PHASE_SEL_POS = 13;

  // ---------------------------------------------------------------
  // Datapath sizes and values after reset
  // ---------------------------------------------------------------
  localparam int          FREQ_W       = 28;
  localparam int          PHASE_W      = 12;
  localparam int          DAC_W        = 10;
  localparam int          QUARTER_W    = 5;
  localparam int          AMP_W        = 9;
  localparam logic [9:0]  DAC_MIDSCALE = 10'h200;
  localparam logic [9:0]  DAC_LOW_MID  = 10'h1FF;
  localparam logic [13:0] CTRL_RESET   = 14'h0000;
  localparam logic [27:0] FREQ_RESET   = 28'h0000000;
  localparam logic [11:0] PHASE_RESET  = 12'h000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  kind;
    logic [13:0] payload;
  } serial_word_t;

  typedef struct packed {
    logic full_word_write;
    logic upper_half_select;
    logic frequency_bank_select;
    logic phase_bank_select;
    logic rsv9;
    logic clear_acc;
    logic sleep_clk;
    logic sleep_dac;
    logic square_output_enable;
    logic rsv4;
    logic square_halving_select;
    logic rsv2;
    logic mode;
    logic rsv0;
  } ctrl_t;

endpackage

// File: sine_lookup_table.sv
`timescale 1ns/1ps
module sine_lookup_table
  import nco_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic [PHASE_W-1:0] phase,
  output logic      [DAC_W-1:0]   code_q
);

  // ---------------------------------------------------------------
  // Quarter-wave amplitude table
  // ---------------------------------------------------------------
  localparam logic [AMP_W-1:0] QUARTER [32] = '{
    9'h00D, 9'h026, 9'h03F, 9'h057, 9'h070, 9'h088, 9'h0A0, 9'h0B8,
    9'h0CF, 9'h0E6, 9'h0FC, 9'h111, 9'h126, 9'h13A, 9'h14E, 9'h160,
    9'h172, 9'h183, 9'h193, 9'h1A2, 9'h1B0, 9'h1BD, 9'h1C9, 9'h1D3,
    9'h1DD, 9'h1E6, 9'h1ED, 9'h1F3, 9'h1F7, 9'h1FB, 9'h1FE, 9'h1FF
  };

  logic [QUARTER_W-1:0] index;
  logic [AMP_W-1:0]     amp;

  // Mirror the index in the second and fourth quarter
  assign index = phase[10] ? ~phase[9:5] : phase[9:5];
  assign amp   = QUARTER[index];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= DAC_MIDSCALE;
    end else if (phase[11]) begin
      code_q <= DAC_LOW_MID - {1'b0, amp};
    end else begin
      code_q <= DAC_MIDSCALE + {1'b0, amp};
    end
  end

endmodule

// File: square_halver.sv
`timescale 1ns/1ps
module square_halver
  import nco_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clear,
  input  wire logic bit_in,
  output logic      half_q
);

  logic prev_q;

  // ---------------------------------------------------------------
  // Toggle on each rising edge of the input bit
  // ---------------------------------------------------------------
  // Midscale has its top bit set, so no false edge follows a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b1;
      half_q <= 1'b0;
    end else if (clear) begin
      prev_q <= 1'b1;
      half_q <= 1'b0;
    end else begin
      prev_q <= bit_in;
      if (bit_in && !prev_q) begin
        half_q <= ~half_q;
      end
    end
  end

endmodule

// File: nco_waveform_core.sv
`timescale 1ns/1ps
// Contract
// - D3 picks square MSB or MSB halved.
// - Mode one sends truncated phase: triangle.
// - Mode zero uses sine table.
// - Bank select zero uses frequency word A.
// - Bank select one uses frequency word B.
// - Phase select zero adds offset A.
// - Phase select one adds offset B.
// - Output frequency is clock times word over 2^28.
// - Phase shift is 2 pi times offset/4096.
// - D5 routes square bit instead of converter.
// - D8 clears accumulator, output goes midscale.
// - Kinds 01/10 load frequency words, 14-bit halves.
// - Kind 11 loads offset chosen by D13.
module nco_waveform_core
  import nco_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             sclk,
  input  wire logic             fsync_n,
  input  wire logic             sdata,
  output logic      [DAC_W-1:0] dac_code_q,
  output logic                  dac_drives_pin_q,
  output logic                  square_pin_q
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sclk_sync_q;
  logic [1:0] fsync_sync_q;
  logic [1:0] sdata_sync_q;
  logic       sclk_fall;
  logic       framing;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_sync_q  <= 3'h7;
      fsync_sync_q <= 2'h3;
      sdata_sync_q <= 2'h0;
    end else begin
      sclk_sync_q  <= {sclk_sync_q[1:0], sclk};
      fsync_sync_q <= {fsync_sync_q[0], fsync_n};
      sdata_sync_q <= {sdata_sync_q[0], sdata};
    end
  end

  assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
  assign framing   = !fsync_sync_q[1];

  // ---------------------------------------------------------------
  // Serial word receiver
  // ---------------------------------------------------------------
  logic [WORD_W-2:0] shift_q;
  logic [3:0]        bit_cnt_q;
  logic              word_stb_q;
  serial_word_t      word_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q    <= '0;
      bit_cnt_q  <= 4'h0;
      word_stb_q <= 1'b0;
      word_q     <= '0;
    end else begin
      word_stb_q <= 1'b0;
      if (!framing) begin
        bit_cnt_q <= 4'h0;
      end else if (sclk_fall) begin
        shift_q   <= {shift_q[WORD_W-3:0], sdata_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == LAST_BIT) begin
          word_q     <= {shift_q, sdata_sync_q[1]};
          word_stb_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Control word
  // ---------------------------------------------------------------
  ctrl_t ctrl_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (word_stb_q && word_q.kind == KIND_CONTROL) begin
      ctrl_q <= word_q.payload;
    end
  end

  // ---------------------------------------------------------------
  // Frequency words
  // ---------------------------------------------------------------
  logic [FREQ_W-1:0]    frequency_word_q [2];
  logic [PAYLOAD_W-1:0] lsb_stage_q;
  logic                 lsb_pend_q;
  logic                 pend_bank_q;
  logic                 freq_write;
  logic                 freq_bank;

  assign freq_write = word_stb_q && (word_q.kind == KIND_FREQ_A || word_q.kind == KIND_FREQ_B);
  assign freq_bank  = (word_q.kind == KIND_FREQ_B);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frequency_word_q[0] <= FREQ_RESET;
      frequency_word_q[1] <= FREQ_RESET;
      lsb_stage_q         <= '0;
      lsb_pend_q          <= 1'b0;
      pend_bank_q         <= 1'b0;
    end else if (word_stb_q && word_q.kind == KIND_CONTROL) begin
      lsb_pend_q <= 1'b0;
    end else if (freq_write) begin
      if (!ctrl_q.full_word_write) begin
        if (ctrl_q.upper_half_select) begin
          frequency_word_q[freq_bank][FREQ_W-1:PAYLOAD_W] <= word_q.payload;
        end else begin
          frequency_word_q[freq_bank][PAYLOAD_W-1:0] <= word_q.payload;
        end
      end else if (!lsb_pend_q || pend_bank_q != freq_bank) begin
        lsb_stage_q <= word_q.payload;
        lsb_pend_q  <= 1'b1;
        pend_bank_q <= freq_bank;
      end else begin
        frequency_word_q[freq_bank] <= {word_q.payload, lsb_stage_q};
        lsb_pend_q                  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Phase offsets
  // ---------------------------------------------------------------
  logic [PHASE_W-1:0] phase_offset_q [2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_offset_q[0] <= PHASE_RESET;
      phase_offset_q[1] <= PHASE_RESET;
    end else if (word_stb_q && word_q.kind == KIND_PHASE) begin
      phase_offset_q[word_q.payload[PHASE_SEL_POS]] <= word_q.payload[PHASE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Phase accumulator and phase adder
  // ---------------------------------------------------------------
  logic [FREQ_W-1:0]  selected_frequency_word;
  logic [PHASE_W-1:0] selected_phase_offset;
  logic [FREQ_W-1:0]  acc_q;
  logic [PHASE_W-1:0] phase_q;

  assign selected_frequency_word = frequency_word_q[ctrl_q.frequency_bank_select];
  assign selected_phase_offset   = phase_offset_q[ctrl_q.phase_bank_select];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
    end else if (ctrl_q.clear_acc) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + selected_frequency_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
    end else if (ctrl_q.clear_acc) begin
      phase_q <= '0;
    end else begin
      phase_q <= acc_q[FREQ_W-1:FREQ_W-PHASE_W] + selected_phase_offset;
    end
  end

  // ---------------------------------------------------------------
  // Amplitude paths
  // ---------------------------------------------------------------
  logic [DAC_W-1:0] tri_q;
  logic [DAC_W-1:0] sine_code;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tri_q <= '0;
    end else if (phase_q[PHASE_W-1]) begin
      tri_q <= ~phase_q[PHASE_W-2:1];
    end else begin
      tri_q <= phase_q[PHASE_W-2:1];
    end
  end

  sine_lookup_table u_sine (
    .clk    (clk),
    .arst_n (arst_n),
    .phase  (phase_q),
    .code_q (sine_code)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code_q <= DAC_MIDSCALE;
    end else if (ctrl_q.clear_acc) begin
      dac_code_q <= DAC_MIDSCALE;
    end else if (ctrl_q.mode) begin
      dac_code_q <= tri_q;
    end else begin
      dac_code_q <= sine_code;
    end
  end

  // ---------------------------------------------------------------
  // Output pin routing
  // ---------------------------------------------------------------
  logic square_half;

  square_halver u_half (
    .clk    (clk),
    .arst_n (arst_n),
    .clear  (ctrl_q.clear_acc),
    .bit_in (dac_code_q[DAC_W-1]),
    .half_q (square_half)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_drives_pin_q <= 1'b1;
      square_pin_q     <= 1'b0;
    end else begin
      dac_drives_pin_q <= !ctrl_q.square_output_enable;
      if (!ctrl_q.square_output_enable) begin
        square_pin_q <= 1'b0;
      end else if (ctrl_q.square_halving_select) begin
        square_pin_q <= dac_code_q[DAC_W-1];
      end else begin
        square_pin_q <= square_half;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_acc_bank_a : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.clear_acc && !ctrl_q.frequency_bank_select) |=>
      acc_q == $past(acc_q) + $past(frequency_word_q[0]))
    else $error("accumulator did not add word A");

  a_acc_bank_b : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.clear_acc && ctrl_q.frequency_bank_select) |=>
      acc_q == $past(acc_q) + $past(frequency_word_q[1]))
    else $error("accumulator did not add word B");

  a_acc_clear_zero : assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_q.clear_acc |=> (acc_q == '0 && phase_q == '0 && dac_code_q == DAC_MIDSCALE))
    else $error("clear did not give zero phase and midscale");

  a_phase_offset_a : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.clear_acc && !ctrl_q.phase_bank_select) |=>
      phase_q == $past(acc_q[FREQ_W-1:FREQ_W-PHASE_W]) + $past(phase_offset_q[0]))
    else $error("phase not offset by A");

  a_phase_offset_b : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.clear_acc && ctrl_q.phase_bank_select) |=>
      phase_q == $past(acc_q[FREQ_W-1:FREQ_W-PHASE_W]) + $past(phase_offset_q[1]))
    else $error("phase not offset by B");

  a_tri_path : assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_q.mode && !ctrl_q.clear_acc) |=> dac_code_q == $past(tri_q))
    else $error("triangle not routed to converter");

  a_sine_path : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.mode && !ctrl_q.clear_acc) |=> dac_code_q == $past(sine_code))
    else $error("sine not routed to converter");

  a_square_direct : assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_q.square_output_enable && ctrl_q.square_halving_select) |=>
      (square_pin_q == $past(dac_code_q[DAC_W-1]) && !dac_drives_pin_q))
    else $error("square pin not following MSB");

  a_pin_converter : assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_q.square_output_enable |=> (dac_drives_pin_q && !square_pin_q))
    else $error("converter not driving pin");

  a_phase_load : assert property (@(posedge clk) disable iff (!arst_n)
    (word_stb_q && word_q.kind == KIND_PHASE) |=>
      phase_offset_q[$past(word_q.payload[PHASE_SEL_POS])] == $past(word_q.payload[11:0]))
    else $error("phase offset not loaded");

  c_full_freq_write : cover property (@(posedge clk) disable iff (!arst_n)
    freq_write && ctrl_q.full_word_write && lsb_pend_q);
  c_triangle_mode : cover property (@(posedge clk) disable iff (!arst_n)
    ctrl_q.mode && !ctrl_q.clear_acc);
  c_square_halved : cover property (@(posedge clk) disable iff (!arst_n)
    ctrl_q.square_output_enable && !ctrl_q.square_halving_select && square_pin_q);
  c_phase_b_load : cover property (@(posedge clk) disable iff (!arst_n)
    word_stb_q && word_q.kind == KIND_PHASE && word_q.payload[PHASE_SEL_POS]);

endmodule

// File: serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
  import nco_pkg::*;
(
  input  wire logic clk,
  output logic      sclk,
  output logic      fsync_n,
  output logic      sdata
);
  // ---------------------------------------------------------------
  // Idle pins: clock parked high, frame high
  // ---------------------------------------------------------------
  initial begin
    sclk    = 1'b1;
    fsync_n = 1'b1;
    sdata   = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // One 16-bit word, MSB first, taken on the falling clock edge
  // ---------------------------------------------------------------
  task automatic send_word(input logic [15:0] w);
    logic [15:0] v;
    v = w;
    if (v[15:14] == KIND_CONTROL) begin
      v[4] = 1'b0;
      v[2] = 1'b0;
      v[0] = 1'b0;
      if (v[5]) begin
        v[1] = 1'b0;
      end
    end
    hold(1);
    fsync_n = 1'b0;
    hold(4);
    for (int i = 15; i >= 0; i--) begin
      sdata = v[i];
      sclk  = 1'b1;
      hold(4);
      sclk  = 1'b0;
      hold(4);
    end
    sclk = 1'b1;
    hold(4);
    fsync_n = 1'b1;
    sdata   = ~sdata;
  endtask
endmodule

// File: nco_waveform_core_tb.sv
`timescale 1ns/1ps
module nco_waveform_core_tb
  import nco_pkg::*;
;
  localparam logic [27:0] FA = 28'h0100000;
  localparam logic [27:0] FB = 28'h0080000;

  logic             clk;
  logic             arst_n;
  logic             sclk;
  logic             fsync_n;
  logic             sdata;
  logic [DAC_W-1:0] dac_code_q;
  logic             dac_drives_pin_q;
  logic             square_pin_q;
  int               fail_count;
  int               total_checks;
  int               per;
  int               exp_per;
  logic [15:0]      ctl;

  nco_waveform_core uut (
    .clk              (clk),
    .arst_n           (arst_n),
    .sclk             (sclk),
    .fsync_n          (fsync_n),
    .sdata            (sdata),
    .dac_code_q       (dac_code_q),
    .dac_drives_pin_q (dac_drives_pin_q),
    .square_pin_q     (square_pin_q)
  );

  serial_host_model host (
    .clk     (clk),
    .sclk    (sclk),
    .fsync_n (fsync_n),
    .sdata   (sdata)
  );

  // ---------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_code(input logic [DAC_W-1:0] got, input logic [DAC_W-1:0] exp,
                            input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string msg);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] w);
    host.send_word(w);
    repeat (30) @(posedge clk);
    #1;
  endtask

  function automatic logic [DAC_W-1:0] tri_code(input logic [PHASE_W-1:0] p);
    return p[11] ? ~p[10:1] : p[10:1];
  endfunction

  // Cycles between two rising edges of the square pin
  task automatic period(output int n);
    logic prev;
    int   k;
    n = 0;
    for (int e = 0; e < 2; e++) begin
      k    = 0;
      prev = square_pin_q;
      while (!(prev === 1'b0 && square_pin_q === 1'b1) && k < 3000) begin
        prev = square_pin_q;
        @(posedge clk);
        #1;
        k++;
      end
      n = k;
    end
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    fail_count   = 0;
    total_checks = 0;
    arst_n       = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (1) @(posedge clk);
    #1;
    check_code(dac_code_q, DAC_MIDSCALE, "reset code");
    check_bit(dac_drives_pin_q, 1'b1, "reset drive");
    check_bit(square_pin_q, 1'b0, "reset square");
    $display("test reset done");

    wr(16'h0102);
    wr(16'hC234);
    wr(16'hE9AB);
    wr(16'h0002);
    check_code(dac_code_q, tri_code(12'h234), "triangle offset a");
    check_bit(square_pin_q, 1'b0, "square off");
    wr(16'h0402);
    check_code(dac_code_q, tri_code(12'h9AB), "triangle offset b");
    check_bit(dac_drives_pin_q, 1'b1, "converter drives");
    $display("test triangle done");

    wr(16'hC400);
    wr(16'h0000);
    check_bit(dac_code_q >= 10'h3F0, 1'b1, "sine peak");
    wr(16'hCC00);
    check_bit(dac_code_q <= 10'h00F, 1'b1, "sine trough");
    $display("test sine done");

    wr(16'hC000);
    wr(16'h2000);
    wr({KIND_FREQ_A, FA[13:0]});
    wr({KIND_FREQ_A, FA[27:14]});
    wr(16'h1000);
    wr({KIND_FREQ_B, FB[27:14]});
    wr(16'h0000);
    wr({KIND_FREQ_B, FB[13:0]});
    for (int i = 0; i < 4; i++) begin
      ctl = 16'h0020 | (i[1] ? 16'h0800 : 16'h0000) | (i[0] ? 16'h0000 : 16'h0008);
      exp_per = int'((64'h1 << 28) / (i[1] ? FB : FA)) * (i[0] ? 2 : 1);
      wr(ctl);
      check_bit(dac_drives_pin_q, 1'b0, "square drives");
      period(per);
      check_count(per, exp_per, "square period");
    end
    $display("test frequency done");

    wr(16'h0102);
    check_code(dac_code_q, DAC_MIDSCALE, "clear midscale");
    check_bit(square_pin_q, 1'b0, "clear square");
    repeat (7) @(posedge clk);
    #1;
    check_code(dac_code_q, DAC_MIDSCALE, "clear held");
    wr(16'h0002);
    repeat (64) @(posedge clk);
    #1;
    check_bit(dac_code_q !== DAC_MIDSCALE, 1'b1, "clear released");
    $display("test clear done");
    test_done();
  end
endmodule
